/* File: hw/dss_divider.sv */
// Programmable event divider: one pulse per ratio input events
module dss_divider
    import dss_pkg::*;
#(
    parameter int W = 13
) (
    input  wire logic         clk,     // System clock
    input  wire logic         reset_n, // Asynchronous reset, active low
    input  wire logic         tick,    // One input event
    input  wire logic [W-1:0] ratio,   // Divide ratio, 0 acts as 1
    output logic              pulse    // One-cycle pulse per period
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         pulse;
    } dss_div_type;

    dss_div_type s_r;
    dss_div_type s_nxt;
    logic        lastTick;

    // A lowered ratio ends the period at once instead of wrapping
    assign lastTick = (ratio <= W'(1)) || (W'(s_r.cnt + 1'b1) >= ratio);

    always_comb begin
        s_nxt       = s_r;
        s_nxt.pulse = 1'b0;
        if (tick) begin
            if (lastTick) begin
                s_nxt.cnt   = '0;
                s_nxt.pulse = 1'b1;
            end else begin
                s_nxt.cnt = W'(s_r.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pulse = s_r.pulse;

endmodule // dss_divider

/* File: hw/dss_pkg.sv */
// Shared constants and types of the dual synthesizer serial register load
package dss_pkg;

    // Synchroniser lanes for all asynchronous inputs
    localparam int SYNC_W  = 8;
    localparam int SY_SCLK = 0;
    localparam int SY_DIN  = 1;
    localparam int SY_ENN  = 2;
    localparam int SY_REF  = 3;
    localparam int SY_VCO0 = 4;
    localparam int SY_VCO1 = 5;
    localparam int SY_LD0  = 6;

    // Transfer length decides the target register
    localparam int         CNT_W     = 6;
    localparam int         SHIFT_W   = 32;
    localparam logic [5:0] CTRL_BITS = 6'h08;
    localparam logic [5:0] REF_BITS  = 6'h10;
    localparam logic [5:0] SWAL_BITS = 6'h18;
    localparam logic [5:0] CASC_BITS = 6'h20;
    localparam logic [5:0] CNT_MAX   = 6'h3f;

    // Control byte fields
    localparam int CTRL_W        = 8;
    localparam int CTRL_SIDE_BIT = 7;
    localparam int CTRL_PSC_BIT  = 6;
    localparam int OSEL_LSB      = 0;
    localparam int OSEL_W        = 3;

    // Reference word fields
    localparam int REF_SIDE_BIT = 15;
    localparam int REF_TOP_LSB  = 13;
    localparam int REF_TOP_W    = 3;
    localparam int REF_LOW_W    = 13;

    // Swallow word fields
    localparam int SWAL_SIDE_BIT = 23;
    localparam int N_LSB         = 6;
    localparam int N_W           = 12;
    localparam int A_LSB         = 0;
    localparam int A_W           = 6;
    localparam int FB_W          = 18;

    // Prescaler lower modulus
    localparam logic [FB_W-1:0] PSC_LOW_32 = 18'h00020;
    localparam logic [FB_W-1:0] PSC_LOW_64 = 18'h00040;

    // Configurable output selections
    localparam logic [2:0] OSEL_REF0 = 3'h0;
    localparam logic [2:0] OSEL_REF1 = 3'h1;
    localparam logic [2:0] OSEL_VCO0 = 3'h2;
    localparam logic [2:0] OSEL_VCO1 = 3'h3;
    localparam logic [2:0] OSEL_DOUT = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } dss_port_type;

endpackage // dss_pkg

/* File: hw/dss_serial_load.sv */
// Serial-loaded register set and counters of a dual synthesizer
module dss_serial_load
    import dss_pkg::*;
(
    input  wire logic       clk,          // System clock, 250 MHz
    input  wire logic       reset_n,      // Asynchronous reset, active low
    input  wire logic       sclk,         // Serial clock pin
    input  wire logic       din,          // Serial data pin
    input  wire logic       serialEnN,    // Serial enable pin, active low
    input  wire logic       refInput,     // Reference input pin
    input  wire logic [1:0] vcoIn,        // Prescaled VCO per side
    input  wire logic [1:0] lockDet,      // Lock detector level per side
    output logic            dataOut,      // Serial data to next device
    output logic [1:0]      dividedRef,   // Divided reference pulses
    output logic [1:0]      dividedVco,   // Divided VCO pulses
    output logic            cfgOut,       // Configurable output
    output logic [1:0]      lockOut,      // Open-drain lock level
    output logic [1:0]      lockOutOe     // Lock pin pulls low when high
);

    typedef struct packed {
        logic [SYNC_W-1:0]              sy1;
        logic [SYNC_W-1:0]              sy2;
        logic [SYNC_W-1:0]              prev;
        dss_port_type                   port;
        logic [CNT_W-1:0]               count;
        logic [SHIFT_W-1:0]             shift;
        logic                           dout;
        logic [1:0][CTRL_W-1:0]         ctrl;
        logic [1:0][REF_TOP_W-1:0]      refTop;
        logic [1:0][REF_LOW_W-1:0]      refBuf1;
        logic [1:0][REF_LOW_W-1:0]      refBuf2;
        logic [1:0][N_W-1:0]            nCnt;
        logic [1:0][A_W-1:0]            aCnt;
        logic                           cfgOut;
        logic [1:0]                     lockOe;
    } dss_state_type;

    dss_state_type s_r;
    dss_state_type s_nxt;

    function automatic logic [FB_W-1:0] fbRatio(
        input logic [N_W-1:0] n,
        input logic [A_W-1:0] a,
        input logic           psc64
    );
        logic [FB_W-1:0] p;
        logic [2*FB_W-1:0] prod;
        p    = psc64 ? PSC_LOW_64 : PSC_LOW_32;
        prod = (2*FB_W)'(n) * (2*FB_W)'(p);
        return FB_W'(prod[FB_W-1:0] + FB_W'(a));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Edge events, seen only on the second synchroniser stage
    logic                 sclkRise;
    logic                 enRise;
    logic                 refTick;
    logic [1:0]           vcoTick;
    logic                 inShift;
    logic                 xferCtrl;
    logic                 xferRef;
    logic                 xferSwal;
    logic                 ctrlSide;
    logic                 refSide;
    logic                 swSide;
    logic [CTRL_W-1:0]    ctrlByte;
    logic [REF_TOP_W-1:0] refTopBits;
    logic [REF_LOW_W-1:0] refLow;
    logic [REF_LOW_W-1:0] swBuf1;
    logic [OSEL_W-1:0]    outSel;
    logic [1:0][FB_W-1:0] fbR;

    assign sclkRise = s_r.sy2[SY_SCLK] & ~s_r.prev[SY_SCLK];
    assign enRise   = s_r.sy2[SY_ENN] & ~s_r.prev[SY_ENN];
    assign refTick  = s_r.sy2[SY_REF] & ~s_r.prev[SY_REF];
    assign vcoTick  = s_r.sy2[SY_VCO1:SY_VCO0] & ~s_r.prev[SY_VCO1:SY_VCO0];
    assign inShift  = (s_r.port == ST_SHIFT);
    assign xferCtrl = inShift && enRise
                      && (s_r.count == CTRL_BITS || s_r.count == CASC_BITS);
    assign xferRef  = inShift && enRise && (s_r.count == REF_BITS);
    assign xferSwal = inShift && enRise && (s_r.count == SWAL_BITS);

    assign ctrlSide   = s_r.shift[CTRL_SIDE_BIT];
    assign refSide    = s_r.shift[REF_SIDE_BIT];
    assign swSide     = s_r.shift[SWAL_SIDE_BIT];
    assign ctrlByte   = s_r.shift[CTRL_W-1:0];
    assign refTopBits = s_r.shift[REF_TOP_LSB +: REF_TOP_W];
    assign refLow     = s_r.shift[REF_LOW_W-1:0];
    assign swBuf1     = s_r.refBuf1[swSide];
    // Side 0 control byte owns the shared output pin
    assign outSel     = s_r.ctrl[0][OSEL_LSB +: OSEL_W];

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_nxt      = s_r;
        s_nxt.sy1  = {lockDet, vcoIn, refInput, serialEnN, din, sclk};
        s_nxt.sy2  = s_r.sy1;
        s_nxt.prev = s_r.sy2;
        // Oldest bit of the shifter leaves toward the next cascaded device
        s_nxt.dout = s_r.shift[SHIFT_W-1];
        case (s_r.port)
            ST_IDLE: begin
                if (!s_r.sy2[SY_ENN]) begin
                    s_nxt.port  = ST_SHIFT;
                    s_nxt.count = '0;
                end
            end
            ST_SHIFT: begin
                if (sclkRise) begin
                    s_nxt.shift = {s_r.shift[SHIFT_W-2:0], s_r.sy2[SY_DIN]};
                    if (s_r.count != CNT_MAX) begin
                        s_nxt.count = CNT_W'(s_r.count + 1'b1);
                    end
                end
                if (enRise) begin
                    s_nxt.port = ST_IDLE;
                end
                if (xferCtrl) begin
                    s_nxt.ctrl[ctrlSide] = ctrlByte;
                end
                if (xferRef) begin
                    s_nxt.refTop[refSide]  = refTopBits;
                    s_nxt.refBuf1[refSide] = refLow;
                end
                if (xferSwal) begin
                    s_nxt.nCnt[swSide]    = s_r.shift[N_LSB +: N_W];
                    s_nxt.aCnt[swSide]    = s_r.shift[A_LSB +: A_W];
                    s_nxt.refBuf2[swSide] = swBuf1;
                end
            end
            default: begin
                s_nxt.port = ST_IDLE;
            end
        endcase
        case (outSel)
            OSEL_REF0: s_nxt.cfgOut = dividedRef[0];
            OSEL_REF1: s_nxt.cfgOut = dividedRef[1];
            OSEL_VCO0: s_nxt.cfgOut = dividedVco[0];
            OSEL_VCO1: s_nxt.cfgOut = dividedVco[1];
            OSEL_DOUT: s_nxt.cfgOut = s_r.dout;
            default:   s_nxt.cfgOut = 1'b0;
        endcase
        s_nxt.lockOe = ~s_r.sy2[SY_LD0 +: 2];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r      <= '0;
            s_r.port <= ST_IDLE;
            // Enable idles high; a zero here would fake a frame after reset
            s_r.sy1[SY_ENN]  <= 1'b1;
            s_r.sy2[SY_ENN]  <= 1'b1;
            s_r.prev[SY_ENN] <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters per side
    for (genvar i = 0; i < 2; i++) begin : g_side
        assign fbR[i] = fbRatio(s_r.nCnt[i], s_r.aCnt[i],
                                s_r.ctrl[i][CTRL_PSC_BIT]);

        dss_divider #(.W(REF_LOW_W)) u_ref (
            .clk     (clk),
            .reset_n (reset_n),
            .tick    (refTick),
            .ratio   (s_r.refBuf2[i]),
            .pulse   (dividedRef[i])
        );

        dss_divider #(.W(FB_W)) u_fb (
            .clk     (clk),
            .reset_n (reset_n),
            .tick    (vcoTick[i]),
            .ratio   (fbR[i]),
            .pulse   (dividedVco[i])
        );
    end

    assign dataOut   = s_r.dout;
    assign cfgOut    = s_r.cfgOut;
    // Open-drain: the level is always low, only the enable moves
    assign lockOut   = 2'b00;
    assign lockOutOe = s_r.lockOe;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seqRefWrite;
        inShift ##0 enRise ##0 (s_r.count == REF_BITS);
    endsequence

    sequence seqSwalWrite;
        inShift ##0 enRise ##0 (s_r.count == SWAL_BITS);
    endsequence

    a_ctrl_store: assert property (
        xferCtrl |=> s_r.ctrl[$past(ctrlSide)] == $past(ctrlByte)
            && $stable(s_r.refBuf1) && $stable(s_r.refBuf2)
            && $stable(s_r.nCnt) && $stable(s_r.aCnt))
        else $error("control write stored wrong data");

    a_swal_copy: assert property (
        seqSwalWrite |=> s_r.refBuf2[$past(swSide)] == $past(swBuf1))
        else $error("second reference buffer not loaded");

    a_ratio_hold: assert property (
        !xferSwal |=> $stable(s_r.refBuf2) && $stable(s_r.nCnt)
            && $stable(s_r.aCnt))
        else $error("ratio changed without swallow write");

    a_swal_keep: assert property (
        seqSwalWrite |=> $stable(s_r.refBuf1) && $stable(s_r.ctrl))
        else $error("swallow write touched reference or control");

    a_ref_top: assert property (
        seqRefWrite |=> s_r.refTop[$past(refSide)] == $past(refTopBits))
        else $error("reference top bits not stored");

    a_ref_buffer: assert property (
        seqRefWrite |=> s_r.refBuf1[$past(refSide)] == $past(refLow)
            && $stable(s_r.refBuf2))
        else $error("reference write reached the counter");

    a_fb_ratio: assert property (
        fbR[0] == (s_r.ctrl[0][CTRL_PSC_BIT]
            ? {s_r.nCnt[0], 6'h00} : {1'b0, s_r.nCnt[0], 5'h00})
            + {12'h000, s_r.aCnt[0]})
        else $error("feedback ratio wrong");

    a_lock_drain: assert property (
        !s_r.sy2[SY_LD0] |=> lockOutOe[0] && (lockOut == 2'b00))
        else $error("lock output not open-drain");

    a_cfg_dout: assert property (
        (outSel == OSEL_DOUT) |=> cfgOut == $past(s_r.dout))
        else $error("configurable output missed data out");

    a_xfer_enable: assert property (
        (inShift && !enRise) |=> $stable(s_r.ctrl) && $stable(s_r.refBuf1)
            && $stable(s_r.nCnt))
        else $error("register changed while enable low");

endmodule // dss_serial_load

/* File: verif/dss_host_model.sv */
// Host controller model driving the synthesizer serial port
module dss_host_model (
    input  wire logic clk,       // System clock
    output logic      sclk,      // Serial clock, still outside frames
    output logic      din,       // Serial data, MSB first
    output logic      serialEnN  // Serial enable, active low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk      = 1'b0;
        din       = 1'b0;
        serialEnN = 1'b1;
    end

    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic send(input logic [31:0] word, input int nBits);
        serialEnN = 1'b0;
        waitClk(4);
        for (int i = nBits - 1; i >= 0; i--) begin
            din = word[i];
            waitClk(8);
            sclk = 1'b1;
            waitClk(8);
            sclk = 1'b0;
        end
        waitClk(8);
        serialEnN = 1'b1;
        waitClk(8);
        // Released line must not look like the last bit
        din = ~din;
        waitClk(8);
    endtask
endmodule // dss_host_model

/* File: verif/test_dss_serial_load.sv */
// Self-checking bench of the dual synthesizer serial register load
module test_dss_serial_load
    import dss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk;
    logic       reset_n;
    logic       sclk;
    logic       din;
    logic       serialEnN;
    logic       refInput;
    logic [1:0] vcoIn;
    logic [1:0] lockDet;
    logic       dataOut;
    logic       cfgOut;
    logic [1:0] dividedRef;
    logic [1:0] dividedVco;
    logic [1:0] lockOut;
    logic [1:0] lockOutOe;
    int         errors;
    int         nCompared;
    int         cntRef;
    int         cntVco;
    int         cntCfg;

    dss_serial_load DUT (.clk(clk), .reset_n(reset_n), .sclk(sclk),
        .din(din), .serialEnN(serialEnN), .refInput(refInput),
        .vcoIn(vcoIn), .lockDet(lockDet), .dataOut(dataOut),
        .dividedRef(dividedRef), .dividedVco(dividedVco),
        .cfgOut(cfgOut), .lockOut(lockOut), .lockOutOe(lockOutOe));

    dss_host_model host (.clk(clk), .sclk(sclk), .din(din),
        .serialEnN(serialEnN));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Counted on the falling edge, well away from the launching edge
    always @(negedge clk) begin
        if (dividedRef[0] === 1'b1) cntRef++;
        if (dividedVco[0] === 1'b1) cntVco++;
        if (cfgOut === 1'b1) cntCfg++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finishTest;
        $display("errors %0d compared %0d", errors, nCompared);
        if (errors == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %0h expected %0h",
                     $time, msg, seen, exp);
        end
    endtask

    // Source 0 reference, 1 and 2 prescaled VCO of each side
    task automatic edges(input int src, input int n);
        repeat (n) begin
            if (src == 0) refInput = 1'b1; else vcoIn[src-1] = 1'b1;
            repeat (4) @(posedge clk);
            #1;
            if (src == 0) refInput = 1'b0; else vcoIn[src-1] = 1'b0;
            repeat (4) @(posedge clk);
            #1;
        end
        repeat (8) @(posedge clk);
        #1;
    endtask

    // Settling edges first, so a reload mid-period is not counted
    task automatic measure(input int src, input int settle, input int n);
        edges(src, settle);
        cntRef = 0;
        cntVco = 0;
        cntCfg = 0;
        edges(src, n);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic lockLevels;
        lockDet = 2'b01;
        repeat (8) @(posedge clk);
        #1;
        check(lockOutOe, 2'b10, "lock enable");
        check(lockOut, 2'b00, "lock level");
        lockDet = 2'b10;
        repeat (8) @(posedge clk);
        #1;
        check(lockOutOe, 2'b01, "lock enable swap");
    endtask

    task automatic ctrlSelect;
        for (int sel = 0; sel < 4; sel++) begin
            host.send(32'(sel), 8);
            measure((sel < 2) ? 0 : sel - 1, 0, 4);
            check(cntCfg, 4, "cfg source");
        end
        host.send(32'h05, 8);
        measure(0, 0, 4);
        check(cntCfg, 0, "cfg low");
    endtask

    task automatic refHold;
        host.send(32'h00, 8);
        // Ratio 3: reference rate over comparison rate
        host.send(32'h0003, 16);
        measure(0, 0, 6);
        check(cntRef, 6, "ref ratio kept");
    endtask

    task automatic swallowLoad;
        host.send(32'h000041, 24);
        measure(0, 3, 6);
        check(cntRef, 2, "ref ratio loaded");
        measure(1, 33, 66);
        check(cntVco, 2, "feedback 32 mode");
    endtask

    task automatic sideAndCount;
        host.send(32'h05, 8);
        host.send(32'h80, 8);
        host.send(32'h000, 12);
        measure(0, 0, 6);
        check(cntCfg, 0, "other side or bad count");
    endtask

    // Whole frame sits in the shifter: its first bit stands on data out
    task automatic dataPass;
        host.send(32'h80000004, 32);
        check(dataOut, 1'b1, "data out high");
        check(cfgOut, 1'b1, "cfg carries data out");
        host.send(32'h00000004, 32);
        check(dataOut, 1'b0, "data out low");
        check(cfgOut, 1'b0, "cfg follows data out");
    endtask

    task automatic cascadeLoad;
        host.send(32'h5a3c9640, 32);
        host.send(32'h000041, 24);
        measure(0, 3, 6);
        check(cntRef, 2, "first buffer kept");
        check(cntCfg, 2, "cascade control");
        measure(1, 65, 130);
        check(cntVco, 2, "feedback 64 mode");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n   = 1'b0;
        refInput  = 1'b0;
        vcoIn     = 2'b00;
        lockDet   = 2'b00;
        errors    = 0;
        nCompared = 0;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        lockLevels;
        ctrlSelect;
        refHold;
        swallowLoad;
        sideAndCount;
        dataPass;
        cascadeLoad;
        finishTest;
    end

    // Whole run is near 30 us
    initial begin
        #120000;
        errors++;
        finishTest;
    end
endmodule // test_dss_serial_load
